// ==== design/tdt_wave_gen.sv ====
// timer, transfer engine and toggle port that emulate a clock or pwm output
//
// Added by the designer: register access over Avalon-MM and the register addresses.
`include "tdt_params.svh"

// Notes on behaviour
// - timer counts down; at zero it triggers and reloads from its reload register
// - timer n triggers transfer channel n; only channels 0 to 3 have timers
// - toggle register write inverts pins written one, zeros leave pins alone
// - clock mode moves one 32-bit word, size code 2, mask to toggle register
// - clock mode gives 50% square wave, at most timer rate over two
// - toggle channel completion starts linked channel that rewrites the reload register
// - reload channel moves words, source plus 4, two iterations, then source minus 8
// - reload alternates between first and second stored word, setting high and low
// - duty runs 0% to 100%; neither end holds the pin steady, the pin still toggles twice per period
// - at 0% or 100% duty brief spikes may appear on the output
// - the port takes one trigger source, so one pin per port
// - reload values below 30 give about 300 ns of edge jitter
module tdt_wave_gen (
    // clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // avalon-mm slave
    input wire logic [8:0] avs_address,
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic [31:0] avs_writedata,
    input wire logic [3:0] avs_byteenable,
    output logic [31:0] avs_readdata,
    output logic avs_waitrequest,
    // port pins
    output logic [31:0] gpio_out,
    output logic [31:0] gpio_oe
);

    // ==========================================================
    // declarations
    tdt_pkg::tdt_state_s st;
    tdt_pkg::tdt_state_s next_st;
    tdt_pkg::tdt_desc_s d;
    tdt_pkg::tdt_desc_s rdesc;
    logic [5:0] mem_addr;
    logic mem_we;
    logic [31:0] mem_wdata;
    logic [31:0] mem_rdata;
    logic [3:0] trig;
    logic [7:0] clr_req;
    logic [7:0] set_req;
    logic [7:0] err_set;
    logic [7:0] err_clr;
    logic [2:0] ch;
    logic [1:0] tidx;
    logic [31:0] rd;
    logic [31:0] w;
    logic [3:0] nxt_iter;
    logic bus_start;

    // lowest channel in a request vector
    function automatic logic [2:0] tdt_first(input logic [7:0] v);
        logic [2:0] r;
        r = 3'h0;
        for (int k = 7; k >= 0; k--) begin
            if (v[k]) begin
                r = 3'(k);
            end
        end
        return r;
    endfunction : tdt_first

    // byte-lane merge of write data into an old word
    function automatic logic [31:0] tdt_merge(input logic [31:0] old, input logic [31:0] nw,
                                              input logic [3:0] be);
        logic [31:0] r;
        r = old;
        for (int k = 0; k < 4; k++) begin
            if (be[k]) begin
                r[k*8 +: 8] = nw[k*8 +: 8];
            end
        end
        return r;
    endfunction : tdt_merge

    // ==========================================================
    // table memory
    tdt_table_ram u_table (
        .clk(clk),
        .addr(mem_addr),
        .we(mem_we),
        .wdata(mem_wdata),
        .rdata(mem_rdata)
    );

    // ==========================================================
    // read value of the addressed register
    always_comb begin
        rd = 32'h0000_0000;
        rdesc = st.desc[avs_address[6:4]];
        if (avs_address[8]) begin
            rd = mem_rdata;
        end else if (avs_address[8:7] == 2'b01) begin
            unique case (avs_address[3:2])
                2'h0: rd = {24'h00_0000, rdesc.cur};
                2'h1: rd = {21'h00_0000, rdesc.ssize, 5'h00, rdesc.dsize};
                2'h2: rd = {16'h0000, rdesc.slast, rdesc.soff};
                2'h3: rd = {13'h0000, rdesc.dest, 1'b0, rdesc.link_ch, 3'h0, rdesc.link_en,
                            rdesc.iter, rdesc.loop};
            endcase
        end else if (avs_address[8:6] == 3'b001) begin
            rd = avs_address[2] ? st.count[avs_address[4:3]] : st.reload[avs_address[4:3]];
        end else begin
            case (avs_address)
                `TDT_OFF_MOD_CTRL: rd = {31'h0000_0000, st.module_off};
                `TDT_OFF_TMR_EN: rd = {28'h000_0000, st.tmr_en};
                `TDT_OFF_PORT_DATA: rd = st.port_data;
                `TDT_OFF_PORT_DIR: rd = st.port_dir;
                `TDT_OFF_PIN_CTRL: rd = {12'h000, st.pin_evt, 13'h0000, st.pin_mux};
                `TDT_OFF_ROUTER: rd = {13'h0000, st.rt_owner, 7'h00, st.rt_en,
                                       2'h0, st.rt_src};
                `TDT_OFF_ERQ: rd = {24'h00_0000, st.erq};
                `TDT_OFF_STATUS: rd = {8'h00, st.err, 7'h00,
                                       (st.eng == tdt_pkg::ENG_XFER), st.pend};
                default: rd = 32'h0000_0000;
            endcase
        end
        w = tdt_merge(rd, avs_writedata, avs_byteenable);
    end

    // ==========================================================
    // next state: timers, transfer engine, bus slave
    always_comb begin
        next_st = st;
        trig = 4'h0;
        clr_req = 8'h00;
        set_req = 8'h00;
        err_set = 8'h00;
        err_clr = 8'h00;
        ch = tdt_first(st.pend & st.erq);
        tidx = 2'h0;
        nxt_iter = 4'h0;
        mem_addr = avs_address[7:2];
        mem_we = 1'b0;
        mem_wdata = w;
        bus_start = 1'b0;
        d = st.desc[st.eng_ch]; // descriptor of the channel in flight

        // countdown timers, frozen while the module is off
        for (int i = 0; i < `TDT_NUM_TMR; i++) begin
            if (!st.module_off && st.tmr_en[i]) begin
                if (st.count[i] == 32'h0000_0000) begin
                    trig[i] = 1'b1;
                    next_st.count[i] = st.reload[i];
                end else begin
                    next_st.count[i] = st.count[i] - 32'h0000_0001;
                end
            end
        end

        // timer n requests channel n through the router
        if (st.rt_en && st.rt_src == `TDT_PORT_ID) begin
            set_req[3:0] = trig;
        end

        // transfer engine; a request that is waiting on the bus delays the edge
        unique case (st.eng)
            tdt_pkg::ENG_IDLE: begin
                if (st.bus == tdt_pkg::BUS_IDLE && (st.pend & st.erq) != 8'h00) begin
                    clr_req[ch] = 1'b1;
                    next_st.eng_ch = ch;
                    if (st.desc[ch].ssize == `TDT_SIZE_WORD &&
                        st.desc[ch].dsize == `TDT_SIZE_WORD) begin
                        mem_addr = st.desc[ch].cur[7:2];
                        next_st.eng = tdt_pkg::ENG_XFER;
                    end else begin
                        err_set[ch] = 1'b1;
                    end
                end
            end
            tdt_pkg::ENG_XFER: begin
                if (d.dest == `TDT_DEST_TOGGLE) begin
                    if (st.rt_owner == st.eng_ch) begin
                        next_st.port_data = st.port_data ^ mem_rdata;
                    end else begin
                        err_set[st.eng_ch] = 1'b1;
                    end
                end else if (d.dest <= `TDT_DEST_RELOAD_LAST) begin
                    tidx = 2'(d.dest - 3'h1);
                    next_st.reload[tidx] = mem_rdata;
                end else begin
                    err_set[st.eng_ch] = 1'b1;
                end
                nxt_iter = d.iter + 4'h1;
                if (nxt_iter >= d.loop) begin
                    next_st.desc[st.eng_ch].cur = d.cur + d.soff + d.slast;
                    next_st.desc[st.eng_ch].iter = 4'h0;
                    if (d.link_en) begin
                        set_req[d.link_ch] = 1'b1;
                    end
                end else begin
                    next_st.desc[st.eng_ch].cur = d.cur + d.soff;
                    next_st.desc[st.eng_ch].iter = nxt_iter;
                end
                next_st.eng = tdt_pkg::ENG_IDLE;
            end
        endcase

        // bus slave: answer two cycles after the request is taken, once the engine is idle and no enabled request is pending
        unique case (st.bus)
            tdt_pkg::BUS_IDLE: begin
                bus_start = (avs_read || avs_write) && st.eng == tdt_pkg::ENG_IDLE &&
                            (st.pend & st.erq) == 8'h00;
                if (bus_start) begin
                    next_st.bus = tdt_pkg::BUS_READ;
                end
            end
            tdt_pkg::BUS_READ: begin
                next_st.rdata = rd;
                next_st.waitreq = 1'b0;
                next_st.bus = tdt_pkg::BUS_DONE;
            end
            tdt_pkg::BUS_DONE: begin
                next_st.waitreq = 1'b1;
                next_st.bus = tdt_pkg::BUS_IDLE;
                if (avs_write) begin
                    if (avs_address[8]) begin
                        mem_we = 1'b1;
                    end else if (avs_address[8:7] == 2'b01) begin
                        unique case (avs_address[3:2])
                            2'h0: begin
                                next_st.desc[avs_address[6:4]].src = w[7:0];
                                next_st.desc[avs_address[6:4]].cur = w[7:0];
                            end
                            2'h1: begin
                                next_st.desc[avs_address[6:4]].ssize = w[10:8];
                                next_st.desc[avs_address[6:4]].dsize = w[2:0];
                            end
                            2'h2: begin
                                next_st.desc[avs_address[6:4]].soff = w[7:0];
                                next_st.desc[avs_address[6:4]].slast = w[15:8];
                            end
                            2'h3: begin
                                next_st.desc[avs_address[6:4]].loop = w[3:0];
                                next_st.desc[avs_address[6:4]].iter = 4'h0;
                                next_st.desc[avs_address[6:4]].link_en = w[8];
                                next_st.desc[avs_address[6:4]].link_ch = w[14:12];
                                next_st.desc[avs_address[6:4]].dest = w[18:16];
                            end
                        endcase
                    end else if (avs_address[8:6] == 3'b001) begin
                        if (!avs_address[2] && !st.module_off) begin
                            next_st.reload[avs_address[4:3]] = w;
                        end
                    end else begin
                        case (avs_address)
                            `TDT_OFF_MOD_CTRL: next_st.module_off = w[0];
                            `TDT_OFF_TMR_EN: begin
                                if (!st.module_off) begin
                                    next_st.tmr_en = w[3:0];
                                    for (int i = 0; i < `TDT_NUM_TMR; i++) begin
                                        if (w[i] && !st.tmr_en[i]) begin
                                            next_st.count[i] = next_st.reload[i];
                                        end
                                    end
                                end
                            end
                            `TDT_OFF_PORT_DATA: next_st.port_data = w;
                            `TDT_OFF_PORT_TOGGLE: next_st.port_data = st.port_data ^ w;
                            `TDT_OFF_PORT_DIR: next_st.port_dir = w;
                            `TDT_OFF_PIN_CTRL: begin
                                next_st.pin_mux = w[2:0];
                                next_st.pin_evt = w[19:16];
                            end
                            `TDT_OFF_ROUTER: begin
                                next_st.rt_src = w[5:0];
                                next_st.rt_en = w[8];
                                next_st.rt_owner = w[18:16];
                            end
                            `TDT_OFF_ERQ: next_st.erq = w[7:0];
                            `TDT_OFF_STATUS: err_clr = avs_writedata[23:16] &
                                                       {8{avs_byteenable[2]}};
                            default: ;
                        endcase
                    end
                end
            end
            default: begin
                next_st.waitreq = 1'b1;
                next_st.bus = tdt_pkg::BUS_IDLE;
            end
        endcase

        // request and error flags, a new set wins over a clear in the same cycle
        next_st.pend = (st.pend & ~clr_req) | set_req;
        next_st.err = (st.err & ~err_clr) | err_set;

        // pin drivers follow direction only while the pin is routed to gpio
        next_st.port_oe = (next_st.pin_mux == `TDT_MUX_GPIO) ? next_st.port_dir
                                                              : 32'h0000_0000;
    end

    // ==========================================================
    // state register
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            st <= '0;
            st.module_off <= `TDT_RST_MOD_OFF;
            st.waitreq <= `TDT_RST_WAITREQ;
        end else begin
            st <= next_st;
        end
    end

    // ==========================================================
    // outputs straight from the state register
    assign avs_readdata = st.rdata;
    assign avs_waitrequest = st.waitreq;
    assign gpio_out = st.port_data;
    assign gpio_oe = st.port_oe;

endmodule : tdt_wave_gen

// ==== design/tdt_params.svh ====
// offsets, field values, reset values and timing counts of the toggle waveform block
`ifndef TDT_PARAMS_SVH
`define TDT_PARAMS_SVH

// ==========================================================
// structure
`define TDT_NUM_TMR 4
`define TDT_NUM_CH 8
`define TDT_TABLE_AW 6

// ==========================================================
// register byte offsets
`define TDT_OFF_MOD_CTRL 9'h000
`define TDT_OFF_TMR_EN 9'h004
`define TDT_OFF_PORT_DATA 9'h008
`define TDT_OFF_PORT_TOGGLE 9'h00C
`define TDT_OFF_PORT_DIR 9'h010
`define TDT_OFF_PIN_CTRL 9'h014
`define TDT_OFF_ROUTER 9'h018
`define TDT_OFF_ERQ 9'h01C
`define TDT_OFF_STATUS 9'h020
`define TDT_OFF_RELOAD_BASE 9'h040
`define TDT_OFF_DESC_BASE 9'h080
`define TDT_OFF_TABLE_BASE 9'h100

// ==========================================================
// field values
`define TDT_SIZE_WORD 3'h2
`define TDT_MUX_GPIO 3'h1
`define TDT_EVT_EITHER 4'h3
`define TDT_PORT_ID 6'h34
`define TDT_DEST_TOGGLE 3'h0
`define TDT_DEST_RELOAD_LAST 3'h4

// ==========================================================
// reset values
`define TDT_RST_MOD_OFF 1'b1
`define TDT_RST_WAITREQ 1'b1

// ==========================================================
// timing
`define TDT_CLK_MHZ 20
`define TDT_JITTER_NS 300
`define TDT_JITTER_CYC ((`TDT_JITTER_NS * `TDT_CLK_MHZ + 999) / 1000)
`define TDT_SMALL_RELOAD 32'h0000_001E

`endif

// ==== design/tdt_pkg.sv ====
// types of the toggle waveform block
package tdt_pkg;

    // ==========================================================
    // state encodings
    typedef enum logic [0:0] {ENG_IDLE, ENG_XFER} tdt_eng_e;
    typedef enum logic [1:0] {BUS_IDLE, BUS_READ, BUS_DONE} tdt_bus_e;

    // ==========================================================
    // one transfer descriptor
    typedef struct packed {
        logic [7:0] src;
        logic [7:0] cur;
        logic [2:0] ssize;
        logic [2:0] dsize;
        logic [7:0] soff;
        logic [7:0] slast;
        logic [3:0] loop;
        logic [3:0] iter;
        logic link_en;
        logic [2:0] link_ch;
        logic [2:0] dest;
    } tdt_desc_s;

    // ==========================================================
    // whole state of the top module
    typedef struct packed {
        logic module_off;
        logic [3:0] tmr_en;
        logic [3:0][31:0] reload;
        logic [3:0][31:0] count;
        logic [31:0] port_data;
        logic [31:0] port_dir;
        logic [31:0] port_oe;
        logic [2:0] pin_mux;
        logic [3:0] pin_evt;
        logic [5:0] rt_src;
        logic rt_en;
        logic [2:0] rt_owner;
        logic [7:0] erq;
        logic [7:0] pend;
        logic [7:0] err;
        tdt_desc_s [7:0] desc;
        tdt_eng_e eng;
        logic [2:0] eng_ch;
        tdt_bus_e bus;
        logic waitreq;
        logic [31:0] rdata;
    } tdt_state_s;

endpackage : tdt_pkg

// ==== design/tdt_table_ram.sv ====
// word table holding pin masks and reload values, registered read
module tdt_table_ram (
    // clock
    input wire logic clk,
    // access port
    input wire logic [5:0] addr,
    input wire logic we,
    input wire logic [31:0] wdata,
    output logic [31:0] rdata
);

    logic [31:0] mem [0:63];

    // ==========================================================
    // write and registered read
    always_ff @(posedge clk) begin
        if (we) begin
            mem[addr] <= wdata;
        end
        rdata <= mem[addr];
    end

endmodule : tdt_table_ram

// ==== test/tdt_pin_load.sv ====
// load on the emulated output pin, measures cycles between pin edges
module tdt_pin_load (
    // clock and measurement enable
    input wire logic clk,
    input wire logic arm,
    // pin as driven by the block
    input wire logic pin_out,
    input wire logic pin_oe,
    // span between the last two edges
    output logic seen,
    output logic [31:0] span
);
    timeunit 1ns;
    timeprecision 1ns;
    logic level;
    logic last;
    logic started;
    logic [31:0] cnt;
    // =========================================================
    // pin level
    // a released pin is pulled low by the load
    assign level = pin_oe ? pin_out : 1'b0;
    // =========================================================
    // edge timing
    // first edge after arming only starts the count
    initial seen = 1'b0;
    always @(posedge clk) begin
        seen <= 1'b0;
        if (!arm) begin
            started <= 1'b0;
            cnt <= 32'h0000_0000;
            last <= level;
        end else if (level !== last) begin
            last <= level;
            cnt <= 32'h0000_0001;
            started <= 1'b1;
            seen <= started;
            span <= cnt;
        end else begin
            cnt <= cnt + 32'h0000_0001;
        end
    end
endmodule : tdt_pin_load

// ==== test/tdt_wave_gen_sva.sv ====
// port checker of the toggle waveform block
`include "tdt_params.svh"
module tdt_wave_gen_sva (
    // clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // avalon-mm slave
    input wire logic [8:0] avs_address,
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic [31:0] avs_writedata,
    input wire logic [3:0] avs_byteenable,
    input wire logic [31:0] avs_readdata,
    input wire logic avs_waitrequest,
    // port pins
    input wire logic [31:0] gpio_out,
    input wire logic [31:0] gpio_oe
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_n);
    logic ack_wr;
    logic ack_rd;
    logic [8:0] word;
    // =========================================================
    // helpers
    // completed accesses and word address
    assign ack_wr = avs_write && !avs_waitrequest;
    assign ack_rd = avs_read && !avs_waitrequest;
    assign word = avs_address & 9'h1FC;
    // =========================================================
    // bus handshake
    chk_reset_idle: assert property ($rose(rst_n) |-> avs_waitrequest && gpio_out == 32'h0000_0000)
        else $error("bus or pins not idle after reset");
    chk_ack_single: assert property (!avs_waitrequest |=> avs_waitrequest)
        else $error("waitrequest low longer than one cycle");
    chk_ack_cause: assert property (!avs_waitrequest |-> $past(avs_read || avs_write)
        && $past(avs_read || avs_write, 2))
        else $error("answer without a held request");
    chk_ack_bound: assert property ($rose(avs_read || avs_write) |-> ##[2:40] !avs_waitrequest)
        else $error("request not answered in time");
    chk_rdata_hold: assert property (!$stable(avs_readdata) |-> !avs_waitrequest)
        else $error("read data changed outside an answer");
    // =========================================================
    // port behaviour
    chk_toggle_invert: assert property (
        ack_wr && word == `TDT_OFF_PORT_TOGGLE && avs_byteenable == 4'hF
        |=> gpio_out == ($past(gpio_out) ^ $past(avs_writedata)))
        else $error("toggle write did not invert the chosen pins");
    chk_toggle_reads_zero: assert property (
        ack_rd && word == `TDT_OFF_PORT_TOGGLE |-> avs_readdata == 32'h0000_0000)
        else $error("toggle register read not zero");
    chk_data_write: assert property (
        ack_wr && word == `TDT_OFF_PORT_DATA && avs_byteenable == 4'hF
        |=> gpio_out == $past(avs_writedata))
        else $error("port data write not on pins");
    chk_pin_spacing: assert property (
        $changed(gpio_out) && !$past(ack_wr) |=> $stable(gpio_out))
        else $error("pin toggled faster than half the count rate");
    chk_oe_by_write: assert property (!$stable(gpio_oe) |-> $past(ack_wr))
        else $error("drive enable changed without a write");
    // =========================================================
    // main scenarios
    cov_toggle: cover property (ack_wr && word == `TDT_OFF_PORT_TOGGLE);
    cov_read: cover property (ack_rd);
    cov_engine: cover property ($changed(gpio_out) && !$past(ack_wr));
endmodule : tdt_wave_gen_sva

bind tdt_wave_gen tdt_wave_gen_sva chk (
    .clk(clk),
    .rst_n(rst_n),
    .avs_address(avs_address),
    .avs_read(avs_read),
    .avs_write(avs_write),
    .avs_writedata(avs_writedata),
    .avs_byteenable(avs_byteenable),
    .avs_readdata(avs_readdata),
    .avs_waitrequest(avs_waitrequest),
    .gpio_out(gpio_out),
    .gpio_oe(gpio_oe)
);

// ==== test/timer_dma_toggle_waveform_test.sv ====
// self-checking bench of the toggle waveform block
`include "tdt_params.svh"
module timer_dma_toggle_waveform_test;
    timeunit 1ns;
    timeprecision 1ns;
    logic clk = 1'b0;
    logic rst_n = 1'b0;
    logic [8:0] avs_address = 9'h000;
    logic avs_read = 1'b0;
    logic avs_write = 1'b0;
    logic [31:0] avs_writedata = 32'h0000_0000;
    logic [3:0] avs_byteenable = 4'hF;
    logic [31:0] avs_readdata;
    logic avs_waitrequest;
    logic [31:0] gpio_out;
    logic [31:0] gpio_oe;
    logic ld_arm = 1'b0;
    logic ld_seen;
    logic [31:0] ld_span;
    logic [31:0] seed = 32'h0000_0427;
    logic [31:0] rq[$];
    logic [31:0] pq[$];
    int n_fail = 0;
    int checked = 0;
    // =========================================================
    // clock and instances
    always #25 clk = ~clk;
    tdt_wave_gen dut (.clk(clk), .rst_n(rst_n), .avs_address(avs_address),
        .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
        .avs_byteenable(avs_byteenable), .avs_readdata(avs_readdata),
        .avs_waitrequest(avs_waitrequest), .gpio_out(gpio_out), .gpio_oe(gpio_oe));
    tdt_pin_load load (.clk(clk), .arm(ld_arm), .pin_out(gpio_out[7]), .pin_oe(gpio_oe[7]),
        .seen(ld_seen), .span(ld_span));
    // =========================================================
    // helpers
    task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
        checked++;
        if (got !== exp) begin
            n_fail++;
            $display("[ERR] %s expected %h seen %h", what, exp, got);
        end
    endtask : check
    function automatic logic [31:0] rnd();
        seed = seed ^ (seed << 13);
        seed = seed ^ (seed >> 17);
        seed = seed ^ (seed << 5);
        return seed;
    endfunction : rnd
    // one access, held until waitrequest is sampled low
    task automatic bus(input logic wr, input logic [8:0] a, input logic [31:0] d);
        int n;
        n = 0;
        avs_address <= a;
        avs_write <= wr;
        avs_read <= !wr;
        avs_writedata <= d;
        do begin
            @(posedge clk);
            n++;
        end while (avs_waitrequest !== 1'b0 && n < 200);
        if (n >= 200) check("waitrequest", 32'h0, 32'h1);
        avs_write <= 1'b0;
        avs_read <= 1'b0;
        @(posedge clk);
    endtask : bus
    task automatic wr(input logic [8:0] a, input logic [31:0] d);
        bus(1'b1, a, d);
    endtask : wr
    task automatic rd(input logic [8:0] a, input logic [31:0] exp);
        rq.push_back(exp);
        bus(1'b0, a, 32'h0000_0000);
    endtask : rd
    // wait until every expected pin span was seen, then disarm the load
    task automatic drain();
        int n;
        n = 0;
        while (pq.size() > 0 && n < 3000) begin
            @(posedge clk);
            n++;
        end
        check("spans left", 32'h0, pq.size());
        ld_arm <= 1'b0;
    endtask : drain
    task automatic final_report();
        $display("checks %0d mismatches %0d", checked, n_fail);
        if (n_fail == 0 && checked > 0) $display("SIMULATION PASSED");
        else $display("SIMULATION FAILED");
        $finish;
    endtask : final_report
    // =========================================================
    // result watchers
    // read data compared in the answer cycle
    always @(posedge clk) begin
        if (avs_read && avs_waitrequest === 1'b0) begin
            if (rq.size() == 0) check("read queue", 32'h1, 32'h0);
            else check("readdata", rq.pop_front(), avs_readdata);
        end
    end
    // pin spans compared as the load reports them
    always @(posedge clk) begin
        if (ld_seen === 1'b1 && ld_arm) begin
            if (pq.size() == 0) check("span queue", 32'h1, 32'h0);
            else check("pin span", pq.pop_front(), ld_span);
        end
    end
    // watchdog
    initial begin
        #(50 * 20000);
        n_fail++;
        $display("[ERR] watchdog expected end seen hang");
        final_report();
    end
    // =========================================================
    // tests
    initial begin
        logic [31:0] d;
        logic [31:0] m;
        logic [31:0] w1;
        logic [31:0] w2;
        repeat (2) @(posedge clk);
        rst_n <= 1'b1;
        @(posedge clk);
        check("gpio_oe", 32'h0000_0000, gpio_oe);
        rd(`TDT_OFF_MOD_CTRL, 32'h0000_0001);
        rd(`TDT_OFF_STATUS, 32'h0000_0000);
        rd(9'h024, 32'h0000_0000);
        wr(`TDT_OFF_RELOAD_BASE, 32'h0000_0055);
        rd(`TDT_OFF_RELOAD_BASE, 32'h0000_0000);
        wr(`TDT_OFF_MOD_CTRL, 32'h0000_0000);
        $display("test reset done");
        for (int i = 0; i < 4; i++) begin
            d = rnd();
            m = rnd();
            wr(`TDT_OFF_PORT_DATA, d);
            wr(`TDT_OFF_PORT_TOGGLE, m);
            rd(`TDT_OFF_PORT_DATA, d ^ m);
            rd(`TDT_OFF_PORT_TOGGLE, 32'h0000_0000);
        end
        wr(`TDT_OFF_PORT_DATA, 32'h0000_0000);
        $display("test toggle done");
        wr(`TDT_OFF_PIN_CTRL, 32'h0003_0001);
        wr(`TDT_OFF_PORT_DIR, 32'h0000_0080);
        check("gpio_oe", 32'h0000_0080, gpio_oe);
        wr(`TDT_OFF_ROUTER, 32'h0000_0134);
        wr(`TDT_OFF_TABLE_BASE, 32'h0000_0080);
        wr(`TDT_OFF_DESC_BASE, 32'h0000_0000);
        wr(`TDT_OFF_DESC_BASE + 9'h004, 32'h0000_0202);
        wr(`TDT_OFF_DESC_BASE + 9'h008, 32'h0000_0000);
        wr(`TDT_OFF_DESC_BASE + 9'h00C, 32'h0000_0001);
        wr(`TDT_OFF_ERQ, 32'h0000_0001);
        wr(`TDT_OFF_RELOAD_BASE, 32'h0000_0009);
        rd(`TDT_OFF_RELOAD_BASE, 32'h0000_0009);
        ld_arm <= 1'b1;
        repeat (4) pq.push_back(32'h0000_000A);
        wr(`TDT_OFF_TMR_EN, 32'h0000_0001);
        drain();
        wr(`TDT_OFF_TMR_EN, 32'h0000_0000);
        $display("test clock done");
        d = rnd();
        w1 = 32'h0000_0008 + {27'h0, d[4:0]};
        w2 = 32'h0000_0008 + {27'h0, d[12:8]};
        wr(`TDT_OFF_TABLE_BASE + 9'h004, w1);
        wr(`TDT_OFF_TABLE_BASE + 9'h008, w2);
        wr(`TDT_OFF_DESC_BASE + 9'h00C, 32'h0000_4101);
        wr(`TDT_OFF_DESC_BASE + 9'h040, 32'h0000_0004);
        wr(`TDT_OFF_DESC_BASE + 9'h044, 32'h0000_0202);
        wr(`TDT_OFF_DESC_BASE + 9'h048, 32'h0000_F804);
        wr(`TDT_OFF_DESC_BASE + 9'h04C, 32'h0001_0002);
        wr(`TDT_OFF_ERQ, 32'h0000_0011);
        wr(`TDT_OFF_RELOAD_BASE, w2);
        ld_arm <= 1'b1;
        for (int i = 0; i < 3; i++) begin
            pq.push_back(w2 + 32'h1);
            pq.push_back(w1 + 32'h1);
        end
        wr(`TDT_OFF_TMR_EN, 32'h0000_0001);
        drain();
        wr(`TDT_OFF_TMR_EN, 32'h0000_0000);
        $display("test pwm done");
        final_report();
    end
endmodule : timer_dma_toggle_waveform_test
